// ### dv/adc_input_mux_control_test.sv
// Self-checking bench for the input multiplexer control block.
// Assumes aimc_pkg and aimc_consts.svh are compiled before it.
`timescale 1ns/10ps
`include "aimc_consts.svh"

module adc_input_mux_control_test;
	import aimc_pkg::*;
	logic           clk;
	logic           srst;
	logic           reg_wr;
	logic           reg_rd;
	logic [7:0]     reg_addr;
	logic [7:0]     reg_wdata;
	logic [7:0]     reg_rdata;
	logic           conv_req;
	logic           conv_start;
	aimc_route_type route;
	logic [12:0]    idac;
	logic [12:0]    burn;
	logic [6:0]     bias;
	logic [3:0]     gpio;
	logic           clk_ext;
	logic           full_scale;
	logic [7:0]     rnd;
	logic [7:0]     mux;
	logic [3:0]     p;
	logic [3:0]     n;
	logic [7:0]     corner [4];
	int             n_fail;
	int             tests_run;
	int             cyc;
	int             starts;

	aimc_mux_ctrl #(.N_AIN(12)) u_dut (
		.CLK(clk), .SRST(srst), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.CONV_REQ(conv_req), .CONV_START(conv_start), .ROUTE(route),
		.IDAC_PINS(idac), .BURNOUT_PINS(burn), .BIAS_PINS(bias),
		.GPIO_ON_AIN(gpio), .CLK_SEL_EXT(clk_ext)
	);

	aimc_sensor_model #(.N_AIN(12)) u_sensor (.burn(burn), .full_scale(full_scale));

	// Clock, 20 ns period
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			$display("timeout");
			wrap_up();
		end
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Switch flags: pos_conn, neg_conn, mid_short, temp, avdd, dvdd
	function automatic logic [15:0] flags();
		return {10'h0, route[5:0]};
	endfunction

	task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic chk_vec(input string w, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic chk_rt(input string w, input aimc_route_type e);
		tests_run++;
		if (route !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", w, e, route);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// Ends at the edge that takes the write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input string w, input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		tick(1);
		chk8(w, e, reg_rdata);
	endtask

	// Selection change: two held cycles, then the new pair
	task automatic sel(input logic [7:0] v);
		wr(`AIMC_OFS_MUX, v);
		#1;
		chk_vec("break c1", 16'h08, flags());
		tick(1);
		chk_vec("break c2", 16'h08, flags());
		tick(1);
		chk_rt("route", aimc_route_type'({v, 6'h30}));
		mux = v;
	endtask

	// Selection change with a request at the write edge or one edge later
	task automatic req_in_break(input logic [7:0] v, input bit late);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= `AIMC_OFS_MUX;
		reg_wdata <= v;
		conv_req  <= !late;
		starts = 0;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			reg_wr   <= 1'b0;
			conv_req <= late && (i == 0);
			#1;
			if (conv_start === 1'b1) begin
				starts++;
				chk_vec("start conn", 16'h30, flags());
			end
		end
		chk_vec("pending starts", 16'h1, 16'(starts));
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		conv_req = 1'b0;
		rnd = 8'h27;
		mux = 8'h01;
		corner = '{8'hc0, 8'h0c, 8'hbc, 8'h35};
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		tick(1);
		chk_rt("reset route", aimc_route_type'({8'h01, 6'h30}));
		rd("mux reset", `AIMC_OFS_MUX, 8'h01);
		rd("exc reset", `AIMC_OFS_EXC, 8'hff);
		rd("unmapped", 8'h40, 8'h00);
		done("reset");
		// Common input on either side, then a random mix of pairings
		foreach (corner[i]) sel(corner[i]);
		for (int i = 0; i < 20; i++) begin
			rnd = lfsr(rnd);
			p = (rnd[7:4] > 4'hc) ? rnd[7:4] - 4'h3 : rnd[7:4];
			n = (rnd[3:0] > 4'hc) ? rnd[3:0] - 4'h3 : rnd[3:0];
			if ({p, n} == mux) p = (p == 4'hc) ? 4'h0 : p + 4'h1;
			sel({p, n});
			rd("mux", `AIMC_OFS_MUX, {p, n});
		end
		sel(8'h35);
		wr(`AIMC_OFS_MUX, 8'h35);
		tick(1);
		chk_vec("same value", 16'h30, flags());
		done("selection");
		// Back-to-back starts from a two-cycle request while connected, then no start
		@(posedge clk);
		conv_req <= 1'b1;
		tick(1);
		chk_vec("start 1", 16'h1, {15'h0, conv_start});
		@(posedge clk);
		conv_req <= 1'b0;
		#1;
		chk_vec("start 2", 16'h1, {15'h0, conv_start});
		tick(1);
		chk_vec("start end", 16'h0, {15'h0, conv_start});
		// Request during the hold, or with the write, waits for the connect
		req_in_break(8'h53, 1'b1);
		req_in_break(8'h35, 1'b0);
		sel(8'h53);
		done("conversion");
		// Monitor modes; code 5 means none
		for (int m = 1; m <= 5; m++) begin
			wr(`AIMC_OFS_MON, 8'(m));
			tick(2);
			chk_vec("monitor", (m < 5) ? 16'(4'h8 >> (m - 1)) : 16'h30, flags());
		end
		done("monitor");
		// Sources, bias, shared pins and clock choice
		wr(`AIMC_OFS_EXC, 8'hc2);
		wr(`AIMC_OFS_BIAS, 8'hff);
		wr(`AIMC_OFS_GPIO, 8'h0f);
		wr(`AIMC_OFS_MON, 8'h18);
		tick(2);
		chk_vec("idac", 16'h1004, {3'h0, idac});
		chk_vec("burnout", 16'h0028, {3'h0, burn});
		chk_vec("full scale", 16'h1, {15'h0, full_scale});
		chk_vec("bias", 16'h7f, {9'h0, bias});
		rd("bias", `AIMC_OFS_BIAS, 8'h7f);
		chk_vec("gpio", 16'hf, {12'h0, gpio});
		chk_vec("ext clock", 16'h1, {15'h0, clk_ext});
		wr(`AIMC_OFS_MON, 8'h02);
		tick(2);
		chk_vec("temp", 16'h04, flags());
		wr(`AIMC_OFS_STAT, 8'hff);
		rd("status", `AIMC_OFS_STAT, 8'h00);
		wr(`AIMC_OFS_MUX, 8'h35);
		rd("status break", `AIMC_OFS_STAT, 8'h01);
		done("sources");
		wrap_up();
	end
endmodule // adc_input_mux_control_test

// ### dv/aimc_sensor_model.sv
// Model of external sensors wired to the analog input pins.
// Assumes burn-out enables come straight from the control block.
`timescale 1ns/10ps

module aimc_sensor_model #(
	parameter int         N_AIN     = 12,
	parameter logic [12:0] OPEN_MASK = 13'h0008
) (
	input  wire logic [N_AIN:0] burn,
	output logic                full_scale
);
	// An open sensor under a burn-out source reads full scale
	assign full_scale = |(burn & OPEN_MASK[N_AIN:0]);
endmodule // aimc_sensor_model

// ### inc/aimc_consts.svh
// Constants for the analog input multiplexer control block.
// Assumes the block runs on the converter system clock.
`ifndef AIMC_CONSTS_SVH
`define AIMC_CONSTS_SVH

// Register offsets
`define AIMC_OFS_MUX      8'h02
`define AIMC_OFS_MON      8'h0a
`define AIMC_OFS_EXC      8'h0b
`define AIMC_OFS_BIAS     8'h0c
`define AIMC_OFS_GPIO     8'h0d
`define AIMC_OFS_STAT     8'h0e

// Reset values
`define AIMC_MUX_RST      8'h01
`define AIMC_MON_RST      8'h00
`define AIMC_EXC_RST      8'hff
`define AIMC_BIAS_RST     8'h00
`define AIMC_GPIO_RST     8'h00

// Field positions of the selection register
`define AIMC_POS_MSB      7
`define AIMC_POS_LSB      4
`define AIMC_NEG_MSB      3
`define AIMC_NEG_LSB      0

// Monitor control register fields
`define AIMC_MON_MSB      2
`define AIMC_MON_LSB      0
`define AIMC_BURN_BIT     3
`define AIMC_CLKEXT_BIT   4
`define AIMC_MON_NONE     3'h0
`define AIMC_MON_OFFSET   3'h1
`define AIMC_MON_TEMP     3'h2
`define AIMC_MON_AVDD4    3'h3
`define AIMC_MON_DVDD4    3'h4

// Code of the common input
`define AIMC_CODE_COM     4'hc

// Break hold, in system clock periods, and the derived cycle count
`define AIMC_BBM_TCLK     2
`define AIMC_BBM_CYCLES   (`AIMC_BBM_TCLK * 1)

`endif

// ### inc/aimc_pkg.sv
// Types for the analog input multiplexer control block.
// Assumes aimc_consts.svh supplies all numeric constants.
package aimc_pkg;

	// Break-before-make sequencer states
	typedef enum logic {
		AIMC_CONNECTED,
		AIMC_BREAK
	} aimc_seq_type;

	// Switch controls toward the amplifier inputs
	typedef struct packed {
		logic [3:0] pos_sel;
		logic [3:0] neg_sel;
		logic       pos_conn;
		logic       neg_conn;
		logic       mid_short;
		logic       temp_sel;
		logic       avdd_div4;
		logic       dvdd_div4;
	} aimc_route_type;

endpackage

// ### verilog/aimc_mux_ctrl.sv
// Analog input multiplexer control: selection, monitors, sources, break-before-make.
// Assumes register strobes come from the serial port logic on CLK.
`timescale 1ns/10ps
`include "aimc_consts.svh"

// Functional notes
// - Two 4-bit fields at 02h pick positive and negative amplifier inputs.
// - The common input may be picked for either side like any pin.
// - Thirteen or seven inputs, freely mixed single-ended or differential.
// - Offset mode ties both amplifier inputs to mid-supply.
// - Temperature monitor mode routes the die sensor to the converter.
// - Supply monitor modes present analog span over four or digital over four.
// - Burn-out sources act on the inputs selected for conversion.
// - Any selection change holds inputs at mid-supply two clocks before connecting.
// - Excitation currents are routed through the multiplexer onto input pins.
// - Bias voltage reaches only inputs zero to five and the common input.
// - Twelve-input variant shares four GPIO functions with inputs eight to eleven.
// - System clock is internal oscillator or external; sequencing uses it.
module aimc_mux_ctrl
	import aimc_pkg::*;
#(
	parameter int N_AIN = 12
) (
	input  wire logic                 CLK,
	input  wire logic                 SRST,
	input  wire logic                 REG_WR,
	input  wire logic                 REG_RD,
	input  wire logic [7:0]           REG_ADDR,
	input  wire logic [7:0]           REG_WDATA,
	output logic      [7:0]           REG_RDATA,
	input  wire logic                 CONV_REQ,
	output logic                      CONV_START,
	output aimc_pkg::aimc_route_type  ROUTE,
	output logic      [N_AIN:0]       IDAC_PINS,
	output logic      [N_AIN:0]       BURNOUT_PINS,
	output logic      [6:0]           BIAS_PINS,
	output logic      [3:0]           GPIO_ON_AIN,
	output logic                      CLK_SEL_EXT
);
	import aimc_pkg::*;

	logic [7:0]     mux_ff, nxt_mux;
	logic [7:0]     mon_ff, nxt_mon;
	logic [7:0]     exc_ff, nxt_exc;
	logic [6:0]     bias_ff, nxt_bias;
	logic [3:0]     gpio_ff, nxt_gpio;
	logic [7:0]     rdata_ff, nxt_rdata;
	aimc_seq_type   seq_ff, nxt_seq;
	logic [1:0]     hold_ff, nxt_hold;
	logic           pend_ff, nxt_pend;
	logic           start_ff, nxt_start;
	aimc_route_type route_ff, nxt_route;
	logic [N_AIN:0] idac_ff, nxt_idac;
	logic [N_AIN:0] burn_ff, nxt_burn;
	logic [6:0]     biasp_ff, nxt_biasp;
	logic [3:0]     gpo_ff, nxt_gpo;
	logic           clkx_ff, nxt_clkx;
	logic           mux_change;
	logic           live;
	logic [N_AIN:0] idac_a, idac_b, burn_p, burn_n;
	logic [2:0]     mon_sel;

	localparam logic [1:0] HOLD_LAST = 2'(`AIMC_BBM_CYCLES - 1);

	// A write that alters either selection field
	assign mux_change = REG_WR && (REG_ADDR == `AIMC_OFS_MUX) && (REG_WDATA != mux_ff);
	assign mon_sel    = mon_ff[`AIMC_MON_MSB:`AIMC_MON_LSB];
	assign live       = (nxt_seq == AIMC_CONNECTED);

	// Register file next values
	always_comb begin
		nxt_mux   = mux_ff;
		nxt_mon   = mon_ff;
		nxt_exc   = exc_ff;
		nxt_bias  = bias_ff;
		nxt_gpio  = gpio_ff;
		nxt_rdata = rdata_ff;
		if (REG_WR) begin
			unique case (REG_ADDR)
				`AIMC_OFS_MUX:  nxt_mux  = REG_WDATA;
				`AIMC_OFS_MON:  nxt_mon  = {3'h0, REG_WDATA[4:0]};
				`AIMC_OFS_EXC:  nxt_exc  = REG_WDATA;
				`AIMC_OFS_BIAS: nxt_bias = REG_WDATA[6:0];
				`AIMC_OFS_GPIO: nxt_gpio = REG_WDATA[3:0];
				default:        nxt_mux  = mux_ff;
			endcase
		end
		if (REG_RD) begin
			unique case (REG_ADDR)
				`AIMC_OFS_MUX:  nxt_rdata = mux_ff;
				`AIMC_OFS_MON:  nxt_rdata = mon_ff;
				`AIMC_OFS_EXC:  nxt_rdata = exc_ff;
				`AIMC_OFS_BIAS: nxt_rdata = {1'b0, bias_ff};
				`AIMC_OFS_GPIO: nxt_rdata = {4'h0, gpio_ff};
				`AIMC_OFS_STAT: nxt_rdata = {6'h0, pend_ff, seq_ff == AIMC_BREAK};
				default:        nxt_rdata = 8'h00;
			endcase
		end
	end

	// Register file storage
	always_ff @(posedge CLK) begin
		if (SRST) begin
			mux_ff   <= `AIMC_MUX_RST;
			mon_ff   <= `AIMC_MON_RST;
			exc_ff   <= `AIMC_EXC_RST;
			bias_ff  <= 7'(`AIMC_BIAS_RST);
			gpio_ff  <= 4'(`AIMC_GPIO_RST);
			rdata_ff <= 8'h00;
		end else begin
			mux_ff   <= nxt_mux;
			mon_ff   <= nxt_mon;
			exc_ff   <= nxt_exc;
			bias_ff  <= nxt_bias;
			gpio_ff  <= nxt_gpio;
			rdata_ff <= nxt_rdata;
		end
	end

	// Break-before-make sequencer and conversion gating
	// A change inside the break restarts the hold; requests wait in pend_ff
	always_comb begin
		nxt_seq   = seq_ff;
		nxt_hold  = hold_ff;
		nxt_start = 1'b0;
		nxt_pend  = pend_ff | CONV_REQ;
		if (mux_change) begin
			nxt_seq  = AIMC_BREAK;
			nxt_hold = 2'h0;
		end else begin
			unique case (seq_ff)
				AIMC_CONNECTED: begin
					nxt_start = pend_ff | CONV_REQ;
				end
				AIMC_BREAK: begin
					if (hold_ff == HOLD_LAST) begin
						nxt_seq = AIMC_CONNECTED;
					end else begin
						nxt_hold = hold_ff + 2'h1;
					end
				end
			endcase
		end
		if (nxt_start) begin
			nxt_pend = 1'b0;
		end
	end

	// Sequencer state, timed on the system clock
	always_ff @(posedge CLK) begin
		if (SRST) begin
			seq_ff   <= AIMC_CONNECTED;
			hold_ff  <= 2'h0;
			pend_ff  <= 1'b0;
			start_ff <= 1'b0;
		end else begin
			seq_ff   <= nxt_seq;
			hold_ff  <= nxt_hold;
			pend_ff  <= nxt_pend;
			start_ff <= nxt_start;
		end
	end

	// Decoders for excitation and burn-out targets
	aimc_pin_decode #(.N_AIN(N_AIN)) u_idac_a (
		.code (nxt_exc[3:0]),
		.en   (1'b1),
		.pins (idac_a)
	);
	aimc_pin_decode #(.N_AIN(N_AIN)) u_idac_b (
		.code (nxt_exc[7:4]),
		.en   (1'b1),
		.pins (idac_b)
	);
	aimc_pin_decode #(.N_AIN(N_AIN)) u_burn_p (
		.code (nxt_mux[`AIMC_POS_MSB:`AIMC_POS_LSB]),
		.en   (live && nxt_mon[`AIMC_BURN_BIT]),
		.pins (burn_p)
	);
	aimc_pin_decode #(.N_AIN(N_AIN)) u_burn_n (
		.code (nxt_mux[`AIMC_NEG_MSB:`AIMC_NEG_LSB]),
		.en   (live && nxt_mon[`AIMC_BURN_BIT]),
		.pins (burn_n)
	);

	// Switch controls from the next state
	always_comb begin
		nxt_route           = '0;
		nxt_route.pos_sel   = nxt_mux[`AIMC_POS_MSB:`AIMC_POS_LSB];
		nxt_route.neg_sel   = nxt_mux[`AIMC_NEG_MSB:`AIMC_NEG_LSB];
		if (!live) begin
			nxt_route.mid_short = 1'b1;
		end else begin
			unique case (nxt_mon[`AIMC_MON_MSB:`AIMC_MON_LSB])
				`AIMC_MON_OFFSET: nxt_route.mid_short = 1'b1;
				`AIMC_MON_TEMP:   nxt_route.temp_sel  = 1'b1;
				`AIMC_MON_AVDD4:  nxt_route.avdd_div4 = 1'b1;
				`AIMC_MON_DVDD4:  nxt_route.dvdd_div4 = 1'b1;
				default: begin
					nxt_route.pos_conn = 1'b1;
					nxt_route.neg_conn = 1'b1;
				end
			endcase
		end
		nxt_idac  = idac_a | idac_b;
		nxt_burn  = burn_p | burn_n;
		nxt_biasp = nxt_bias;
		nxt_gpo   = (N_AIN == 12) ? nxt_gpio : 4'h0;
		nxt_clkx  = nxt_mon[`AIMC_CLKEXT_BIT];
	end

	// Output flops
	always_ff @(posedge CLK) begin
		if (SRST) begin
			route_ff <= '{pos_sel: 4'h0, neg_sel: 4'h1, mid_short: 1'b0, temp_sel: 1'b0,
				avdd_div4: 1'b0, dvdd_div4: 1'b0, pos_conn: 1'b1, neg_conn: 1'b1};
			idac_ff  <= '0;
			burn_ff  <= '0;
			biasp_ff <= 7'h00;
			gpo_ff   <= 4'h0;
			clkx_ff  <= 1'b0;
		end else begin
			route_ff <= nxt_route;
			idac_ff  <= nxt_idac;
			burn_ff  <= nxt_burn;
			biasp_ff <= nxt_biasp;
			gpo_ff   <= nxt_gpo;
			clkx_ff  <= nxt_clkx;
		end
	end

	assign REG_RDATA    = rdata_ff;
	assign CONV_START   = start_ff;
	assign ROUTE        = route_ff;
	assign IDAC_PINS    = idac_ff;
	assign BURNOUT_PINS = burn_ff;
	assign BIAS_PINS    = biasp_ff;
	assign GPIO_ON_AIN  = gpo_ff;
	assign CLK_SEL_EXT  = clkx_ff;

	// Checks on the sequencer and routing
	a_break_entry: assert property (@(posedge CLK) disable iff (SRST)
		mux_change |=> ROUTE.mid_short && !ROUTE.pos_conn && !ROUTE.neg_conn)
		else $error("inputs not parked at mid-supply after selection change");

	a_break_two_clk: assert property (@(posedge CLK) disable iff (SRST)
		mux_change ##1 !mux_change [*2] |=> seq_ff == AIMC_CONNECTED && $past(seq_ff, 2) == AIMC_BREAK)
		else $error("break interval is not two clocks");

	a_sel_tracks: assert property (@(posedge CLK) disable iff (SRST)
		ROUTE.pos_conn |-> ROUTE.pos_sel == mux_ff[7:4] && ROUTE.neg_sel == mux_ff[3:0])
		else $error("connected selection differs from register");

	a_start_gate: assert property (@(posedge CLK) disable iff (SRST)
		CONV_START |-> seq_ff == AIMC_CONNECTED && !$past(mux_change))
		else $error("conversion started while inputs detached");

	a_offset_mode: assert property (@(posedge CLK) disable iff (SRST)
		seq_ff == AIMC_CONNECTED && mon_sel == `AIMC_MON_OFFSET |-> ROUTE.mid_short && !ROUTE.pos_conn)
		else $error("offset mode did not short inputs");

	a_temp_mode: assert property (@(posedge CLK) disable iff (SRST)
		seq_ff == AIMC_CONNECTED && mon_sel == `AIMC_MON_TEMP |-> ROUTE.temp_sel && !ROUTE.mid_short)
		else $error("temperature sensor not routed");

	a_supply_mode: assert property (@(posedge CLK) disable iff (SRST)
		ROUTE.avdd_div4 || ROUTE.dvdd_div4 |-> (mon_sel == `AIMC_MON_AVDD4) == ROUTE.avdd_div4
		&& !ROUTE.pos_conn)
		else $error("supply monitor routing wrong");

	a_burn_gate: assert property (@(posedge CLK) disable iff (SRST)
		BURNOUT_PINS != '0 |-> mon_ff[`AIMC_BURN_BIT] && ROUTE.pos_conn == (mon_sel == 3'h0 ||
		mon_sel > 3'h4))
		else $error("burn-out active without enable or connection");

	a_gpio_share: assert property (@(posedge CLK) disable iff (SRST)
		GPIO_ON_AIN == ((N_AIN == 12) ? gpio_ff : 4'h0))
		else $error("gpio sharing does not follow the variant");

	a_pending_kept: assert property (@(posedge CLK) disable iff (SRST)
		CONV_REQ && mux_change ##1 !mux_change [*3] |-> !CONV_START ##1 CONV_START)
		else $error("pending conversion lost across break");

	a_break_held: assert property (@(posedge CLK) disable iff (SRST)
		$past(mux_change) || $past(mux_change, 2) |-> ROUTE.mid_short && !ROUTE.pos_conn)
		else $error("inputs connected inside the break interval");

	a_idac_common: assert property (@(posedge CLK) disable iff (SRST)
		IDAC_PINS[N_AIN] == (exc_ff[3:0] == `AIMC_CODE_COM || exc_ff[7:4] == `AIMC_CODE_COM))
		else $error("excitation current on common input differs from register");

	a_clk_choice: assert property (@(posedge CLK) disable iff (SRST)
		CLK_SEL_EXT == mon_ff[`AIMC_CLKEXT_BIT])
		else $error("clock source choice differs from register");

	a_pend_clear: assert property (@(posedge CLK) disable iff (SRST)
		CONV_START |-> !pend_ff)
		else $error("request still pending after start");

endmodule // aimc_mux_ctrl

// ### verilog/aimc_pin_decode.sv
// One-hot decoder from an input code to a pin enable vector.
// Assumes codes below N_AIN are analog pins and the common code is the top bit.
`timescale 1ns/10ps
`include "aimc_consts.svh"

module aimc_pin_decode #(
	parameter int N_AIN = 12
) (
	input  wire logic [3:0]     code,
	input  wire logic           en,
	output logic      [N_AIN:0] pins
);

	// Unknown codes select nothing
	always_comb begin
		pins = '0;
		if (en) begin
			if (code == `AIMC_CODE_COM) begin
				pins[N_AIN] = 1'b1;
			end else if ({28'h0, code} < N_AIN) begin
				pins[code] = 1'b1;
			end
		end
	end

endmodule // aimc_pin_decode
